// File: core/bbcfg_pkg.sv
// constants and types of the buck-boost configuration and status register bank
package bbcfg_pkg;
	// register offsets
	localparam logic [7:0] OFS_FLAG_CLEAR = 8'h03;
	localparam logic [7:0] OFS_POWER_PATH_STATUS = 8'h21;
	localparam logic [7:0] OFS_FAULT_SUMMARY = 8'h78;
	localparam logic [7:0] OFS_POWER_PATH_CONTROL = 8'h81;
	localparam logic [7:0] OFS_CONVERTER_CONFIG_0 = 8'hd0;
	localparam logic [7:0] OFS_CONVERTER_CONFIG_1 = 8'hd1;
	localparam logic [7:0] OFS_SLEW_DISCHARGE = 8'hd2;
	localparam logic [7:0] OFS_INPUT_PROTECT = 8'hd3;
	localparam logic [7:0] OFS_INPUT_DETECT_RISE = 8'hd4;
	localparam logic [7:0] OFS_POWER_STAGE = 8'hd6;
	localparam logic [7:0] OFS_LOOP_SHAPING = 8'hd7;
	localparam logic [7:0] OFS_FEEDBACK = 8'hd8;
	// reset values
	localparam logic [7:0] RST_POWER_PATH_CONTROL = 8'h00;
	localparam logic [7:0] RST_CONVERTER_CONFIG_0 = 8'h20;
	localparam logic [7:0] RST_CONVERTER_CONFIG_1 = 8'h09;
	localparam logic [7:0] RST_SLEW_DISCHARGE = 8'h42;
	localparam logic [7:0] RST_INPUT_PROTECT = 8'ha0;
	localparam logic [7:0] RST_INPUT_DETECT_RISE = 8'h03;
	localparam logic [7:0] RST_POWER_STAGE = 8'h15;
	localparam logic [7:0] RST_LOOP_SHAPING = 8'h15;
	localparam logic [7:0] RST_FEEDBACK = 8'h8b;
	// implemented-bit masks
	localparam logic [7:0] MSK_POWER_PATH_STATUS = 8'h40;
	localparam logic [7:0] MSK_POWER_PATH_CONTROL = 8'h03;
	localparam logic [7:0] MSK_CONVERTER_CONFIG_0 = 8'h7f;
	localparam logic [7:0] MSK_SLEW_DISCHARGE = 8'h7f;
	localparam logic [7:0] MSK_INPUT_DETECT_RISE = 8'h1f;
	localparam logic [7:0] MSK_LOOP_SHAPING = 8'h3f;
	// field positions
	localparam int BIT_CONST_CURRENT = 6;
	localparam int BIT_BUSY = 7;
	localparam int BIT_OFF = 6;
	localparam int BIT_OVERVOLTAGE = 5;
	localparam int BIT_OVERCURRENT = 4;
	localparam int BIT_UNDERVOLTAGE = 3;
	localparam int BIT_TEMPERATURE = 2;
	localparam int BIT_COMM_LOGIC_MEM = 1;
	localparam int BIT_OTHER = 0;
	localparam int BIT_FORCE_DRAIN = 1;
	localparam int BIT_STAGE_ON = 0;
	localparam int BIT_NEG_LIMIT = 6;
	localparam int BIT_AUX_REG = 5;
	localparam int BIT_IMON_LIMITER = 4;
	localparam int BIT_HICCUP = 3;
	localparam int BIT_DUAL_SPREAD = 2;
	localparam int BIT_MICRO_SLEEP = 1;
	localparam int BIT_THERMAL_WARN = 7;
	localparam int POS_THERMAL_LEVEL = 5;
	localparam int BIT_FAULT_IRQ_MODE = 4;
	localparam int BIT_TRACK_DIRECT = 3;
	localparam int BIT_BIAS_PRIORITY = 2;
	localparam int BIT_TWO_PHASE_FORCED_PWM = 1;
	localparam int BIT_TWO_PHASE_PSM = 0;
	localparam int BIT_ACTIVE_DOWN_RAMP = 6;
	localparam int POS_SLEW_SEL = 4;
	localparam int POS_DRAIN_CURRENT = 2;
	localparam int BIT_DRAIN_WITH_ENABLE = 1;
	localparam int BIT_DRAIN_TO_THRESHOLD = 0;
	localparam int BIT_INPUT_OV_PROTECT = 7;
	localparam int BIT_INPUT_V_REGULATE = 6;
	localparam int BIT_INPUT_DETECT_ON = 5;
	localparam int POS_SYNC_PIN = 6;
	localparam int BIT_CONST_DEAD_TIME = 5;
	localparam int BIT_DEAD_TIME_SCALING = 4;
	localparam int POS_MIN_DEAD_TIME = 2;
	localparam int POS_MIN_ON_OFF = 0;
	localparam int POS_INDUCTOR_DERATE = 4;
	localparam int POS_SLOPE_COMP = 0;
	localparam int BIT_FEEDBACK_RATIO = 7;
	// decoded-value figures
	localparam logic [15:0] THRESH_FALL_BASE_10MV = 16'h010e;
	localparam logic [15:0] THRESH_RISE_BASE_10MV = 16'h0118;
	localparam logic [15:0] THRESH_STEP_10MV = 16'h0014;
	localparam logic [7:0] VOUT_STEP_DIV20_MV = 8'h14;
	localparam logic [7:0] VOUT_STEP_DIV10_MV = 8'h0a;

	typedef enum logic [1:0] {
		SYNC_IN_RISE = 2'b00,
		SYNC_IN_FALL = 2'b01,
		SYNC_OUT_RISE = 2'b10,
		SYNC_OUT_FALL_180 = 2'b11
	} bbcfg_sync_e;

	typedef enum logic [1:0] {
		DRAIN_IDLE = 2'b00,
		DRAIN_RUN = 2'b01,
		DRAIN_HOLD = 2'b10
	} bbcfg_drain_e;

	// analog status, asynchronous to clk_sys_i
	typedef struct packed {
		logic busy;
		logic unit_off;
		logic output_overvoltage;
		logic output_overcurrent;
		logic input_undervoltage;
		logic temperature;
		logic comm_logic_mem_fault;
		logic other;
		logic const_current_active;
		logic drain_threshold;
		logic tracking_pwm;
	} bbcfg_status_s;

	// decoded settings towards the analog core
	typedef struct packed {
		logic negative_limit_on;
		logic aux_regulator_on;
		logic imon_limiter_on;
		logic hiccup_on;
		logic dual_spread_on;
		logic micro_sleep_on;
		logic thermal_warn_on;
		logic [7:0] thermal_warn_degc;
		logic bias_supply_priority;
		logic active_down_ramp;
		logic [15:0] slew_uv_per_us;
		logic [7:0] drain_current_ma;
		logic input_ov_protect_on;
		logic input_v_regulate_on;
		logic input_detect_on;
		logic [15:0] fall_level_10mv;
		logic [15:0] rise_level_10mv;
		bbcfg_sync_e sync_mode;
		logic const_dead_time;
		logic dead_time_scaling;
		logic [7:0] min_dead_time_ns;
		logic [7:0] min_on_off_pct;
		logic [1:0] inductor_derate_sel;
		logic [15:0] slope_comp_milli;
		logic [7:0] vout_step_mv;
	} bbcfg_cfg_s;
endpackage

// File: core/bbcfg_regs.sv
// register bank with decode and status logic of the buck-boost controller
// How it works
// - unimplemented bits drop written data and read back as zero
// - status bit 6 shows constant-current limiting live, never latched
// - fault byte bit 7 is busy, bit 6 is unit off
// - fault byte bits 5..0 flag overvoltage, overcurrent, undervoltage, temperature, comm, other
// - control bit 1 set starts output drain, clear stops it
// - power stage enabled by either control bit 0 or config0 bit 0
// - config0 resets 20h with limit, aux regulator, limiter, hiccup, spread, sleep enables
// - config1 bit 7 enables thermal warning; 2-bit level 140/125/110/95 degC
// - config1 bit 4 selects fault pin interrupt or indicator behaviour
// - config1 bit 3 lets tracking start without waiting for tracking PWM
// - config1 resets 09h; two-phase in power-save, forced-PWM; bias priority
// - slew field 40/20/1/0.5 mV/us; bit 6 enables active down-ramp
// - drain current 25, 50, 75, 75 mA for codes 0..3
// - slew/drain register resets 42h; bit 1 ties drain to enable, bit 0 holds
// - input-protect resets A0h; bit 7 enables protect, or regulate if bit 6 is set; bit 5 detect
// - falling detect threshold 2.7 V plus 0.2 V per code, reset 0
// - rising detect threshold 2.8 V plus 0.2 V per code, reset 3
// - sync pin role: input rise, input fall, output rise, output fall 180
// - dead time 10/20/40/60 ns; constant-dead-time and scaling enable bits
// - min on/off scale 0.75/1/1.25/1.5, reset code 1
// - slope ratio 0.125 steps for codes 0..7, 0.5 steps 1.5..5 above
// - feedback bit 7 selects ratio 10 or 20, resets to 20
// - output target step is 20 mV at ratio 20, 10 mV at 10
// - any access to the flag-clear address clears all latched flags
`timescale 1ns/1ps
module bbcfg_regs (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	output logic reg_rvalid_o,
	input wire bbcfg_pkg::bbcfg_status_s status_i,
	input wire logic forced_pwm_i,
	input wire logic tracking_enable_i,
	output logic power_stage_on_o,
	output logic drain_active_o,
	output logic two_phase_active_o,
	output logic start_permit_o,
	output logic fault_pin_n_o,
	output bbcfg_pkg::bbcfg_cfg_s cfg_o
);
	import bbcfg_pkg::*;

	// threshold code to level in 10 mV units
	function automatic logic [15:0] detect_level(input logic [15:0] base, input logic [4:0] code);
		logic [15:0] step;
		step = 16'(code) * THRESH_STEP_10MV;
		detect_level = base + step;
	endfunction

	// value with the implemented-bit mask applied
	function automatic logic [7:0] masked(input logic [7:0] value, input logic [7:0] mask);
		masked = value & mask;
	endfunction

	bbcfg_status_s sync1_r;
	bbcfg_status_s sync2_r;
	logic [7:0] ctrl_r;
	logic [7:0] cfg0_r;
	logic [7:0] cfg1_r;
	logic [7:0] slew_r;
	logic [7:0] inprot_r;
	logic [7:0] rise_r;
	logic [7:0] stage_r;
	logic [7:0] loop_r;
	logic [7:0] fb_r;
	logic [5:0] flags_r;
	logic [5:0] flags_nxt;
	logic [5:0] live_faults;
	logic flag_clear;
	logic irq_pend_r;
	logic pwm_prev_r;
	logic pwm_seen_r;
	logic stage_on;
	logic drain_request;
	bbcfg_drain_e drain_state_r;
	bbcfg_drain_e drain_nxt;
	logic [7:0] rd_mux;
	logic [7:0] fault_byte;
	logic [3:0] slope_code;

	// two-stage synchroniser for analog status
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else begin
			sync1_r <= status_i;
			sync2_r <= sync1_r;
		end
	end

	// writable registers, unimplemented bits masked on write
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			ctrl_r <= RST_POWER_PATH_CONTROL;
			cfg0_r <= RST_CONVERTER_CONFIG_0;
			cfg1_r <= RST_CONVERTER_CONFIG_1;
			slew_r <= RST_SLEW_DISCHARGE;
			inprot_r <= RST_INPUT_PROTECT;
			rise_r <= RST_INPUT_DETECT_RISE;
			stage_r <= RST_POWER_STAGE;
			loop_r <= RST_LOOP_SHAPING;
			fb_r <= RST_FEEDBACK;
		end else if (reg_wr_i) begin
			case (reg_addr_i)
				OFS_POWER_PATH_CONTROL: begin
					ctrl_r <= masked(reg_wdata_i, MSK_POWER_PATH_CONTROL);
				end
				OFS_CONVERTER_CONFIG_0: begin
					cfg0_r <= masked(reg_wdata_i, MSK_CONVERTER_CONFIG_0);
				end
				OFS_CONVERTER_CONFIG_1: begin
					cfg1_r <= reg_wdata_i;
				end
				OFS_SLEW_DISCHARGE: begin
					slew_r <= masked(reg_wdata_i, MSK_SLEW_DISCHARGE);
				end
				OFS_INPUT_PROTECT: begin
					inprot_r <= reg_wdata_i;
				end
				OFS_INPUT_DETECT_RISE: begin
					rise_r <= masked(reg_wdata_i, MSK_INPUT_DETECT_RISE);
				end
				OFS_POWER_STAGE: begin
					stage_r <= reg_wdata_i;
				end
				OFS_LOOP_SHAPING: begin
					loop_r <= masked(reg_wdata_i, MSK_LOOP_SHAPING);
				end
				OFS_FEEDBACK: begin
					fb_r <= reg_wdata_i;
				end
				default: begin
				end
			endcase
		end
	end

	// latched fault flags
	assign live_faults = {sync2_r.output_overvoltage, sync2_r.output_overcurrent,
		sync2_r.input_undervoltage, sync2_r.temperature,
		sync2_r.comm_logic_mem_fault, sync2_r.other};
	assign flag_clear = (reg_wr_i | reg_rd_i) && (reg_addr_i == OFS_FLAG_CLEAR);

	// new events win over a clear in the same cycle
	always_comb begin
		flags_nxt = flags_r;
		if (flag_clear) begin
			flags_nxt = '0;
		end
		flags_nxt = flags_nxt | live_faults;
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			flags_r <= '0;
		end else begin
			flags_r <= flags_nxt;
		end
	end

	// summary byte: busy and off live, the rest latched
	always_comb begin
		fault_byte = 8'h00;
		fault_byte[BIT_BUSY] = sync2_r.busy;
		fault_byte[BIT_OFF] = sync2_r.unit_off | ~stage_on;
		fault_byte[BIT_OVERVOLTAGE] = flags_r[5];
		fault_byte[BIT_OVERCURRENT] = flags_r[4];
		fault_byte[BIT_UNDERVOLTAGE] = flags_r[3];
		fault_byte[BIT_TEMPERATURE] = flags_r[2];
		fault_byte[BIT_COMM_LOGIC_MEM] = flags_r[1];
		fault_byte[BIT_OTHER] = flags_r[0];
	end

	// fault pin: interrupt mode holds until cleared, indicator follows flags
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			irq_pend_r <= 1'b0;
		end else if ((flags_nxt & ~flags_r) != 6'h00) begin
			irq_pend_r <= 1'b1;
		end else if (flag_clear) begin
			irq_pend_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			fault_pin_n_o <= 1'b1;
		end else if (cfg1_r[BIT_FAULT_IRQ_MODE]) begin
			fault_pin_n_o <= ~irq_pend_r;
		end else begin
			fault_pin_n_o <= ~(|flags_r);
		end
	end

	// power stage enable from either register
	assign stage_on = ctrl_r[BIT_STAGE_ON] | cfg0_r[BIT_STAGE_ON];

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			power_stage_on_o <= 1'b0;
		end else begin
			power_stage_on_o <= stage_on;
		end
	end

	// output drain sequencing
	assign drain_request = ctrl_r[BIT_FORCE_DRAIN] |
		(slew_r[BIT_DRAIN_WITH_ENABLE] & ~stage_on);

	always_comb begin
		drain_nxt = drain_state_r;
		case (drain_state_r)
			DRAIN_IDLE: begin
				if (drain_request && !sync2_r.drain_threshold) begin
					drain_nxt = DRAIN_RUN;
				end
			end
			DRAIN_RUN: begin
				if (!drain_request) begin
					if (slew_r[BIT_DRAIN_TO_THRESHOLD] && !sync2_r.drain_threshold) begin
						drain_nxt = DRAIN_HOLD;
					end else begin
						drain_nxt = DRAIN_IDLE;
					end
				end else if (slew_r[BIT_DRAIN_TO_THRESHOLD] && sync2_r.drain_threshold) begin
					drain_nxt = DRAIN_IDLE;
				end
			end
			DRAIN_HOLD: begin
				if (sync2_r.drain_threshold) begin
					drain_nxt = DRAIN_IDLE;
				end else if (drain_request) begin
					drain_nxt = DRAIN_RUN;
				end
			end
			default: begin
				drain_nxt = DRAIN_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			drain_state_r <= DRAIN_IDLE;
		end else begin
			drain_state_r <= drain_nxt;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			drain_active_o <= 1'b0;
		end else begin
			drain_active_o <= (drain_nxt != DRAIN_IDLE);
		end
	end

	// tracking PWM edge seen since the stage was enabled
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			pwm_prev_r <= 1'b0;
			pwm_seen_r <= 1'b0;
		end else begin
			pwm_prev_r <= sync2_r.tracking_pwm;
			if (!stage_on) begin
				pwm_seen_r <= 1'b0;
			end else if (sync2_r.tracking_pwm && !pwm_prev_r) begin
				pwm_seen_r <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			start_permit_o <= 1'b0;
			two_phase_active_o <= 1'b0;
		end else begin
			start_permit_o <= stage_on & (~tracking_enable_i | cfg1_r[BIT_TRACK_DIRECT] |
				pwm_seen_r);
			two_phase_active_o <= forced_pwm_i ? cfg1_r[BIT_TWO_PHASE_FORCED_PWM] :
				cfg1_r[BIT_TWO_PHASE_PSM];
		end
	end

	// decoded settings
	assign slope_code = loop_r[POS_SLOPE_COMP +: 4];

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			cfg_o <= '0;
		end else begin
			cfg_o.negative_limit_on <= cfg0_r[BIT_NEG_LIMIT];
			cfg_o.aux_regulator_on <= cfg0_r[BIT_AUX_REG];
			cfg_o.imon_limiter_on <= cfg0_r[BIT_IMON_LIMITER];
			cfg_o.hiccup_on <= cfg0_r[BIT_HICCUP];
			cfg_o.dual_spread_on <= cfg0_r[BIT_DUAL_SPREAD];
			cfg_o.micro_sleep_on <= cfg0_r[BIT_MICRO_SLEEP];
			cfg_o.thermal_warn_on <= cfg1_r[BIT_THERMAL_WARN];
			case (cfg1_r[POS_THERMAL_LEVEL +: 2])
				2'h0: cfg_o.thermal_warn_degc <= 8'h8c;
				2'h1: cfg_o.thermal_warn_degc <= 8'h7d;
				2'h2: cfg_o.thermal_warn_degc <= 8'h6e;
				default: cfg_o.thermal_warn_degc <= 8'h5f;
			endcase
			cfg_o.bias_supply_priority <= cfg1_r[BIT_BIAS_PRIORITY];
			cfg_o.active_down_ramp <= slew_r[BIT_ACTIVE_DOWN_RAMP];
			case (slew_r[POS_SLEW_SEL +: 2])
				2'h0: cfg_o.slew_uv_per_us <= 16'h9c40;
				2'h1: cfg_o.slew_uv_per_us <= 16'h4e20;
				2'h2: cfg_o.slew_uv_per_us <= 16'h03e8;
				default: cfg_o.slew_uv_per_us <= 16'h01f4;
			endcase
			case (slew_r[POS_DRAIN_CURRENT +: 2])
				2'h0: cfg_o.drain_current_ma <= 8'h19;
				2'h1: cfg_o.drain_current_ma <= 8'h32;
				default: cfg_o.drain_current_ma <= 8'h4b;
			endcase
			cfg_o.input_ov_protect_on <= inprot_r[BIT_INPUT_OV_PROTECT] &
				~inprot_r[BIT_INPUT_V_REGULATE];
			cfg_o.input_v_regulate_on <= inprot_r[BIT_INPUT_OV_PROTECT] &
				inprot_r[BIT_INPUT_V_REGULATE];
			cfg_o.input_detect_on <= inprot_r[BIT_INPUT_DETECT_ON];
			cfg_o.fall_level_10mv <= detect_level(THRESH_FALL_BASE_10MV, inprot_r[4:0]);
			cfg_o.rise_level_10mv <= detect_level(THRESH_RISE_BASE_10MV, rise_r[4:0]);
			cfg_o.sync_mode <= bbcfg_sync_e'(stage_r[POS_SYNC_PIN +: 2]);
			cfg_o.const_dead_time <= stage_r[BIT_CONST_DEAD_TIME];
			cfg_o.dead_time_scaling <= stage_r[BIT_DEAD_TIME_SCALING];
			case (stage_r[POS_MIN_DEAD_TIME +: 2])
				2'h0: cfg_o.min_dead_time_ns <= 8'h0a;
				2'h1: cfg_o.min_dead_time_ns <= 8'h14;
				2'h2: cfg_o.min_dead_time_ns <= 8'h28;
				default: cfg_o.min_dead_time_ns <= 8'h3c;
			endcase
			case (stage_r[POS_MIN_ON_OFF +: 2])
				2'h0: cfg_o.min_on_off_pct <= 8'h4b;
				2'h1: cfg_o.min_on_off_pct <= 8'h64;
				2'h2: cfg_o.min_on_off_pct <= 8'h7d;
				default: cfg_o.min_on_off_pct <= 8'h96;
			endcase
			cfg_o.inductor_derate_sel <= loop_r[POS_INDUCTOR_DERATE +: 2];
			if (!slope_code[3]) begin
				cfg_o.slope_comp_milli <= (16'(slope_code) + 16'h0001) * 16'h007d;
			end else begin
				cfg_o.slope_comp_milli <= 16'h05dc + 16'(slope_code[2:0]) * 16'h01f4;
			end
			cfg_o.vout_step_mv <= fb_r[BIT_FEEDBACK_RATIO] ? VOUT_STEP_DIV20_MV :
				VOUT_STEP_DIV10_MV;
		end
	end

	// read multiplexer; unmapped offsets read zero
	always_comb begin
		rd_mux = 8'h00;
		case (reg_addr_i)
			OFS_POWER_PATH_STATUS: begin
				rd_mux[BIT_CONST_CURRENT] = sync2_r.const_current_active;
			end
			OFS_FAULT_SUMMARY: rd_mux = fault_byte;
			OFS_POWER_PATH_CONTROL: rd_mux = masked(ctrl_r, MSK_POWER_PATH_CONTROL);
			OFS_CONVERTER_CONFIG_0: rd_mux = masked(cfg0_r, MSK_CONVERTER_CONFIG_0);
			OFS_CONVERTER_CONFIG_1: rd_mux = cfg1_r;
			OFS_SLEW_DISCHARGE: rd_mux = masked(slew_r, MSK_SLEW_DISCHARGE);
			OFS_INPUT_PROTECT: rd_mux = inprot_r;
			OFS_INPUT_DETECT_RISE: rd_mux = masked(rise_r, MSK_INPUT_DETECT_RISE);
			OFS_POWER_STAGE: rd_mux = stage_r;
			OFS_LOOP_SHAPING: rd_mux = masked(loop_r, MSK_LOOP_SHAPING);
			OFS_FEEDBACK: rd_mux = fb_r;
			default: rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			reg_rdata_o <= 8'h00;
			reg_rvalid_o <= 1'b0;
		end else begin
			reg_rvalid_o <= reg_rd_i;
			if (reg_rd_i) begin
				reg_rdata_o <= rd_mux;
			end
		end
	end
endmodule // bbcfg_regs

// File: verification/bbcfg_host.sv
// host model driving the register strobe port
`timescale 1ns/1ps
module bbcfg_host (
	input wire logic clk_sys_i,
	output logic [7:0] reg_addr_o,
	output logic reg_wr_o,
	output logic [7:0] reg_wdata_o,
	output logic reg_rd_o,
	input wire logic [7:0] reg_rdata_i,
	input wire logic reg_rvalid_i
);
	initial begin
		reg_addr_o = 8'h00;
		reg_wr_o = 1'b0;
		reg_wdata_o = 8'h00;
		reg_rd_o = 1'b0;
	end
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys_i);
		reg_addr_o = a;
		reg_wdata_o = d;
		reg_wr_o = 1'b1;
		@(negedge clk_sys_i);
		reg_wr_o = 1'b0;
		// released data shows no stale value
		reg_wdata_o = ~d;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_sys_i);
		reg_addr_o = a;
		reg_rd_o = 1'b1;
		@(negedge clk_sys_i);
		reg_rd_o = 1'b0;
		reg_addr_o = ~a;
		d = reg_rvalid_i ? reg_rdata_i : 8'hxx;
	endtask
endmodule // bbcfg_host

// File: verification/bbcfg_regs_asserts.sv
// concurrent checks on the ports of the buck-boost register bank
`timescale 1ns/1ps
module bbcfg_regs_asserts (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic reg_rvalid_o,
	input wire bbcfg_pkg::bbcfg_status_s status_i,
	input wire logic power_stage_on_o,
	input wire logic drain_active_o,
	input wire logic fault_pin_n_o,
	input wire bbcfg_pkg::bbcfg_cfg_s cfg_o
);
	import bbcfg_pkg::*;
	logic [10:0] st_prev_r;
	logic [2:0] st_cnt_r;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	// cycles the status inputs have held still, saturating
	always_ff @(posedge clk_sys_i) begin
		st_prev_r <= status_i;
		if (rst_i || status_i != st_prev_r) st_cnt_r <= 3'h0;
		else if (st_cnt_r != 3'h7) st_cnt_r <= st_cnt_r + 3'h1;
	end
	function automatic logic [7:0] imp_mask(input logic [7:0] a);
		return a == 8'h81 ? 8'h03 : a == 8'hd4 ? 8'h1f : a == 8'hd7 ? 8'h3f :
			a == 8'h21 ? 8'h40 : (a == 8'hd0 || a == 8'hd2) ? 8'h7f : 8'hff;
	endfunction
	sequence s_rd(logic [7:0] a);
		reg_rd_i && reg_addr_i == a;
	endsequence
	sequence s_wr(logic [7:0] a);
		reg_wr_i && reg_addr_i == a;
	endsequence
	sequence s_quiet;
		st_cnt_r >= 3'h4;
	endsequence
	property p_rvalid; reg_rd_i |=> reg_rvalid_o; endproperty
	a_rvalid: assert property (p_rvalid) else $error("read not answered");
	property p_no_rvalid; !reg_rd_i |=> !reg_rvalid_o; endproperty
	a_no_rvalid: assert property (p_no_rvalid) else $error("stray read valid");
	property p_unimpl;
		reg_rd_i |=> (reg_rdata_o & ~imp_mask($past(reg_addr_i))) == 8'h00;
	endproperty
	a_unimpl: assert property (p_unimpl) else $error("unimplemented bit reads one");
	property p_cc;
		s_rd(OFS_POWER_PATH_STATUS) ##0 s_quiet |=>
			reg_rdata_o[6] == $past(status_i.const_current_active);
	endproperty
	a_cc: assert property (p_cc) else $error("constant-current bit wrong");
	property p_fault;
		s_rd(OFS_FAULT_SUMMARY) ##0 s_quiet |=> reg_rdata_o[7] == $past(status_i.busy)
			&& ($past(status_i[8:3]) & ~reg_rdata_o[5:0]) == 6'h00
			&& (!$past(status_i.unit_off) || reg_rdata_o[6]);
	endproperty
	a_fault: assert property (p_fault) else $error("fault summary wrong");
	property p_stage;
		s_wr(OFS_POWER_PATH_CONTROL) ##0 reg_wdata_i[0] |=> ##1 power_stage_on_o;
	endproperty
	a_stage: assert property (p_stage) else $error("power stage not enabled");
	property p_drain;
		s_wr(OFS_POWER_PATH_CONTROL) ##0 reg_wdata_i[1] ##0 s_quiet
			##0 !status_i.drain_threshold |-> ##[1:3] drain_active_o;
	endproperty
	a_drain: assert property (p_drain) else $error("output drain not started");
	property p_clear;
		(reg_rd_i || reg_wr_i) && reg_addr_i == OFS_FLAG_CLEAR ##0 s_quiet
			##0 status_i[8:3] == 6'h00 |=> ##1 fault_pin_n_o;
	endproperty
	a_clear: assert property (p_clear) else $error("flag clear left pin low");
	property p_ratio;
		s_wr(OFS_FEEDBACK) |=> ##1
			cfg_o.vout_step_mv == ($past(reg_wdata_i[7], 2) ? 8'h14 : 8'h0a);
	endproperty
	a_ratio: assert property (p_ratio) else $error("output step wrong");
	property p_fall;
		s_wr(OFS_INPUT_PROTECT) |=> ##1
			cfg_o.fall_level_10mv == 16'h010e + 16'h0014 * $past(reg_wdata_i[4:0], 2);
	endproperty
	a_fall: assert property (p_fall) else $error("falling level wrong");
endmodule // bbcfg_regs_asserts

bind bbcfg_regs bbcfg_regs_asserts u_chk (.*);

// File: verification/tb_bbcfg_regs.sv
// self-checking bench for the buck-boost register bank
`timescale 1ns/1ps
module tb_bbcfg_regs;
	import bbcfg_pkg::*;
	typedef struct packed {logic wr; logic [7:0] addr; logic [7:0] wdata; logic [7:0] exp;} bbcfg_row_s;
	logic clk_sys_i, rst_i, reg_wr, reg_rd, rvalid, forced_pwm, tracking_en;
	logic stage_on, drain_on, two_phase, start_permit, fault_pin_n;
	logic [7:0] addr, wdata, rdata, rd_val;
	bbcfg_status_s status;
	bbcfg_cfg_s cfg;
	int err_count, checks_done;
	bbcfg_row_s rows [24] = '{
		'{1'b0, 8'h81, 8'h00, 8'h00}, '{1'b0, 8'hd0, 8'h00, 8'h20}, '{1'b0, 8'hd1, 8'h00, 8'h09},
		'{1'b0, 8'hd2, 8'h00, 8'h42}, '{1'b0, 8'hd3, 8'h00, 8'ha0}, '{1'b0, 8'hd4, 8'h00, 8'h03},
		'{1'b0, 8'hd6, 8'h00, 8'h15}, '{1'b0, 8'hd7, 8'h00, 8'h15}, '{1'b0, 8'hd8, 8'h00, 8'h8b},
		'{1'b0, 8'h21, 8'h00, 8'h00}, '{1'b0, 8'h78, 8'h00, 8'h40}, '{1'b0, 8'h05, 8'h00, 8'h00},
		'{1'b1, 8'h81, 8'hff, 8'h03}, '{1'b1, 8'hd0, 8'hff, 8'h7f}, '{1'b1, 8'hd1, 8'hff, 8'hff},
		'{1'b1, 8'hd2, 8'hff, 8'h7f}, '{1'b1, 8'hd3, 8'hff, 8'hff}, '{1'b1, 8'hd4, 8'hff, 8'h1f},
		'{1'b1, 8'hd6, 8'hff, 8'hff}, '{1'b1, 8'hd7, 8'hff, 8'h3f}, '{1'b1, 8'hd8, 8'h00, 8'h00},
		'{1'b1, 8'h78, 8'hff, 8'h00}, '{1'b1, 8'h21, 8'hff, 8'h00}, '{1'b1, 8'h05, 8'hff, 8'h00}};
	// thermal, slew, drain current, dead time, on/off scale per code
	logic [15:0] tab [5][4] = '{'{16'h008c, 16'h007d, 16'h006e, 16'h005f},
		'{16'h9c40, 16'h4e20, 16'h03e8, 16'h01f4}, '{16'h0019, 16'h0032, 16'h004b, 16'h004b},
		'{16'h000a, 16'h0014, 16'h0028, 16'h003c}, '{16'h004b, 16'h0064, 16'h007d, 16'h0096}};

	bbcfg_host u_host (.clk_sys_i(clk_sys_i), .reg_addr_o(addr), .reg_wr_o(reg_wr),
		.reg_wdata_o(wdata), .reg_rd_o(reg_rd), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid));
	bbcfg_regs u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_addr_i(addr),
		.reg_wr_i(reg_wr), .reg_wdata_i(wdata), .reg_rd_i(reg_rd), .reg_rdata_o(rdata),
		.reg_rvalid_o(rvalid), .status_i(status), .forced_pwm_i(forced_pwm),
		.tracking_enable_i(tracking_en), .power_stage_on_o(stage_on), .drain_active_o(drain_on),
		.two_phase_active_o(two_phase), .start_permit_o(start_permit),
		.fault_pin_n_o(fault_pin_n), .cfg_o(cfg));

	initial begin
		clk_sys_i = 1'b0;
		forever #12.5 clk_sys_i = ~clk_sys_i;
	end
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic wr_wait(input logic [7:0] a, input logic [7:0] d);
		u_host.wr_reg(a, d);
		repeat (2) @(negedge clk_sys_i);
	endtask
	initial begin
		repeat (20000) @(negedge clk_sys_i);
		err_count++;
		end_of_test();
	end
	initial begin
		status = '0;
		forced_pwm = 1'b0;
		tracking_en = 1'b0;
		rst_i = 1'b1;
		repeat (5) @(negedge clk_sys_i);
		rst_i = 1'b0;
		check("stage_rst", 16'(stage_on), 16'h0000);
		check("pin_rst", 16'(fault_pin_n), 16'h0001);
		foreach (rows[i]) begin
			if (rows[i].wr) u_host.wr_reg(rows[i].addr, rows[i].wdata);
			u_host.rd_reg(rows[i].addr, rd_val);
			check($sformatf("reg_%h", rows[i].addr), 16'(rd_val), 16'(rows[i].exp));
		end
		check("vout_step", 16'(cfg.vout_step_mv), 16'h000a);
		check("cfg_en", 16'(cfg[$bits(bbcfg_cfg_s) - 1 -: 7]), 16'h007f);
		wr_wait(OFS_FEEDBACK, 8'h80);
		check("vout_step", 16'(cfg.vout_step_mv), 16'h0014);
		for (int c = 0; c < 4; c++) begin
			u_host.wr_reg(OFS_CONVERTER_CONFIG_1, 8'(c << 5));
			u_host.wr_reg(OFS_SLEW_DISCHARGE, 8'((c << 4) | (c << 2)));
			wr_wait(OFS_POWER_STAGE, 8'((c << 6) | (c << 2) | c));
			check("thermal", 16'(cfg.thermal_warn_degc), tab[0][c]);
			check("slew", cfg.slew_uv_per_us, tab[1][c]);
			check("drain_ma", 16'(cfg.drain_current_ma), tab[2][c]);
			check("sync", 16'(cfg.sync_mode), 16'(c));
			check("dead", 16'(cfg.min_dead_time_ns), tab[3][c]);
			check("on_off", 16'(cfg.min_on_off_pct), tab[4][c]);
		end
		for (int c = 0; c < 16; c++) begin
			wr_wait(OFS_LOOP_SHAPING, 8'(c));
			check("slope", cfg.slope_comp_milli, 16'(c < 8 ? 125 * (c + 1) : 1500 + 500 * (c - 8)));
		end
		for (int c = 0; c < 32; c += 31) begin
			u_host.wr_reg(OFS_INPUT_PROTECT, 8'(c));
			wr_wait(OFS_INPUT_DETECT_RISE, 8'(c));
			check("fall_lvl", cfg.fall_level_10mv, 16'h010e + 16'(20 * c));
			check("rise_lvl", cfg.rise_level_10mv, 16'h0118 + 16'(20 * c));
		end
		status.const_current_active = 1'b1;
		repeat (4) @(negedge clk_sys_i);
		u_host.rd_reg(OFS_POWER_PATH_STATUS, rd_val);
		check("cc_on", 16'(rd_val), 16'h0040);
		status.const_current_active = 1'b0;
		repeat (4) @(negedge clk_sys_i);
		u_host.rd_reg(OFS_POWER_PATH_STATUS, rd_val);
		check("cc_off", 16'(rd_val), 16'h0000);
		for (int i = 0; i < 8; i++) begin
			status[3 + i] = 1'b1;
			repeat (4) @(negedge clk_sys_i);
			u_host.rd_reg(OFS_FAULT_SUMMARY, rd_val);
			check("flag_set", 16'(rd_val), 16'h0001 << i);
			status[3 + i] = 1'b0;
			repeat (4) @(negedge clk_sys_i);
			u_host.rd_reg(OFS_FAULT_SUMMARY, rd_val);
			check("flag_held", 16'(rd_val), i < 6 ? 16'h0001 << i : 16'h0000);
			check("pin", 16'(fault_pin_n), i < 6 ? 16'h0000 : 16'h0001);
			u_host.rd_reg(OFS_FLAG_CLEAR, rd_val);
			u_host.rd_reg(OFS_FAULT_SUMMARY, rd_val);
			check("flag_clr", 16'(rd_val), 16'h0000);
		end
		wr_wait(OFS_CONVERTER_CONFIG_1, 8'h10);
		status.output_overvoltage = 1'b1;
		repeat (4) @(negedge clk_sys_i);
		status.output_overvoltage = 1'b0;
		repeat (4) @(negedge clk_sys_i);
		check("irq_pin", 16'(fault_pin_n), 16'h0000);
		u_host.wr_reg(OFS_FLAG_CLEAR, 8'h00);
		repeat (2) @(negedge clk_sys_i);
		check("irq_pin", 16'(fault_pin_n), 16'h0001);
		wr_wait(OFS_POWER_PATH_CONTROL, 8'h01);
		check("drain", 16'(drain_on), 16'h0000);
		wr_wait(OFS_POWER_PATH_CONTROL, 8'h03);
		check("drain", 16'(drain_on), 16'h0001);
		wr_wait(OFS_POWER_PATH_CONTROL, 8'h01);
		check("drain", 16'(drain_on), 16'h0000);
		wr_wait(OFS_CONVERTER_CONFIG_0, 8'h00);
		check("stage", 16'(stage_on), 16'h0001);
		wr_wait(OFS_POWER_PATH_CONTROL, 8'h00);
		check("stage", 16'(stage_on), 16'h0000);
		wr_wait(OFS_CONVERTER_CONFIG_0, 8'h01);
		check("stage", 16'(stage_on), 16'h0001);
		wr_wait(OFS_CONVERTER_CONFIG_1, 8'h09);
		tracking_en = 1'b1;
		repeat (2) @(negedge clk_sys_i);
		check("two_phase", 16'(two_phase), 16'h0001);
		check("start", 16'(start_permit), 16'h0001);
		forced_pwm = 1'b1;
		wr_wait(OFS_CONVERTER_CONFIG_1, 8'h00);
		check("two_phase", 16'(two_phase), 16'h0000);
		check("start", 16'(start_permit), 16'h0000);
		wr_wait(OFS_SLEW_DISCHARGE, 8'h01);
		wr_wait(OFS_POWER_PATH_CONTROL, 8'h02);
		wr_wait(OFS_POWER_PATH_CONTROL, 8'h00);
		check("drain_hold", 16'(drain_on), 16'h0001);
		status[1:0] = 2'b11;
		repeat (4) @(negedge clk_sys_i);
		check("drain_end", 16'(drain_on), 16'h0000);
		check("start_pwm", 16'(start_permit), 16'h0001);
		end_of_test();
	end
endmodule // tb_bbcfg_regs
